//--- hw/rst_cause_pkg.sv
package rst_cause_pkg;

    // ==========================================================
    // register bits of reset_cause_status
    // ==========================================================
    localparam int POWER_ON_BIT     = 7;
    localparam int PIN_BIT          = 6;
    localparam int WATCHDOG_BIT     = 5;
    localparam int BAD_OPCODE_BIT   = 4;
    localparam int BAD_ADDRESS_BIT  = 3;
    localparam int LOW_VOLTAGE_BIT  = 1;

    // ==========================================================
    // force-reset register
    // ==========================================================
    localparam int FORCE_BIT               = 0;
    localparam logic [7:0] FORCE_READ_VAL  = 8'h00;
    localparam logic [7:0] STATUS_CLEAR    = 8'h00;

    // ==========================================================
    // whole flag words of reset_cause_status
    // ==========================================================
    localparam logic [7:0] POWER_ON_FLAGS    = 8'h82; // power-on plus low-voltage
    localparam logic [7:0] LOW_VOLTAGE_FLAGS = 8'h02; // enabled low-voltage trip alone
    localparam logic [7:0] STATUS_USED_MASK  = 8'hfa; // bits 2 and 0 never read set

    // ==========================================================
    // sequencer timing
    // ==========================================================
    localparam int RESET_HOLD_NS = 160;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_RELEASE
    } seq_state_e;

endpackage

//--- hw/sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // sync2
`default_nettype wire

//--- hw/reset_cause_and_debug_force_reset.sv
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_debug_force_reset #(
    parameter int HOLD_CYCLES = rst_cause_pkg::RESET_HOLD_CYC
) (
    // clock and power-on reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // external pins
    input  wire logic       ext_reset_n,
    input  wire logic       debug_mode_pin,
    // event inputs from same-clock logic
    input  wire logic       low_voltage_trip,
    input  wire logic       low_voltage_reset_enable,
    input  wire logic       watchdog_timeout,
    input  wire logic       watchdog_enable,
    input  wire logic       illegal_opcode,
    input  wire logic       stop_insn,
    input  wire logic       stop_allow,
    input  wire logic       enter_debug_insn,
    input  wire logic       debug_mode_allow,
    input  wire logic       illegal_address,
    // register access
    input  wire logic       status_rd,
    input  wire logic       status_wr,
    input  wire logic       force_rd,
    input  wire logic       force_wr,
    input  wire logic       wr_from_debug,
    input  wire logic [7:0] wr_data,
    output var  logic [7:0] rd_data,
    // outputs
    output var  logic       watchdog_restart,
    output var  logic       chip_reset,
    output var  logic       debug_halt_mode
);

    // ==========================================================
    // elaboration check
    // ==========================================================
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one");
    end

    localparam int CW = $clog2(HOLD_CYCLES + 1);

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [1:0] pin_sync;

    sync2 #(.WIDTH(2)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({~ext_reset_n, ~debug_mode_pin}), // inverted: cleared stages mean idle pins
        .sync_out (pin_sync)
    );

    wire pin_low   = pin_sync[1];
    wire mode_high = ~pin_sync[0];

    // ==========================================================
    // reset source decode
    // ==========================================================
    wire op_bad    = illegal_opcode
                   | (stop_insn & ~stop_allow)
                   | (enter_debug_insn & ~debug_mode_allow);
    wire wd_src    = watchdog_timeout & watchdog_enable;
    wire lv_src    = low_voltage_trip & low_voltage_reset_enable;
    wire force_hit = force_wr & wr_from_debug & wr_data[rst_cause_pkg::FORCE_BIT];
    wire other_src = pin_low | wd_src | op_bad | illegal_address;
    wire any_src   = other_src | lv_src | force_hit;

    // captured flag word for a non-power-on reset
    logic [7:0] cause_word;
    always_comb begin
        cause_word = rst_cause_pkg::STATUS_CLEAR;
        if (force_hit) begin
            cause_word = rst_cause_pkg::STATUS_CLEAR;
        end else if (lv_src && !other_src) begin
            cause_word[rst_cause_pkg::LOW_VOLTAGE_BIT] = 1'b1;
        end else begin
            cause_word[rst_cause_pkg::PIN_BIT]         = pin_low;
            cause_word[rst_cause_pkg::WATCHDOG_BIT]    = wd_src;
            cause_word[rst_cause_pkg::BAD_OPCODE_BIT]  = op_bad;
            cause_word[rst_cause_pkg::BAD_ADDRESS_BIT] = illegal_address;
            cause_word[rst_cause_pkg::LOW_VOLTAGE_BIT] = lv_src;
        end
    end

    // ==========================================================
    // reset sequencer
    // ==========================================================
    rst_cause_pkg::seq_state_e state_q, state_d;
    logic [CW-1:0] hold_q, hold_d;
    logic [7:0]    status_q, status_d;
    logic          forced_q, forced_d;

    wire hold_done = (hold_q == CW'(HOLD_CYCLES - 1));

    // next-state logic
    always_comb begin
        state_d  = state_q;
        hold_d   = hold_q;
        status_d = status_q;
        forced_d = forced_q;
        case (state_q)
            rst_cause_pkg::ST_RUN: begin
                if (any_src) begin
                    state_d  = rst_cause_pkg::ST_HOLD;
                    hold_d   = '0;
                    status_d = cause_word;
                    forced_d = force_hit;
                end
            end
            rst_cause_pkg::ST_HOLD: begin
                if (hold_done && !pin_low) begin
                    state_d = rst_cause_pkg::ST_RELEASE;
                end else if (!hold_done) begin
                    hold_d = hold_q + CW'(1);
                end
            end
            rst_cause_pkg::ST_RELEASE: begin
                state_d = rst_cause_pkg::ST_RUN;
            end
            default: begin
                state_d = rst_cause_pkg::ST_RUN;
            end
        endcase
    end

    // state registers; power-on preset flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= rst_cause_pkg::ST_HOLD;
            hold_q   <= '0;
            status_q <= rst_cause_pkg::POWER_ON_FLAGS;
            forced_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            hold_q   <= hold_d;
            status_q <= status_d;
            forced_q <= forced_d;
        end
    end

    // ==========================================================
    // register read and outputs
    // ==========================================================
    wire [7:0] status_view = status_q & rst_cause_pkg::STATUS_USED_MASK;
    wire [7:0] rd_d = status_rd ? status_view
                    : rst_cause_pkg::FORCE_READ_VAL;
    wire       in_reset_d = (state_d != rst_cause_pkg::ST_RUN);

    // registered outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data          <= 8'h00;
            watchdog_restart <= 1'b0;
            chip_reset       <= 1'b1;
            debug_halt_mode  <= 1'b0;
        end else begin
            rd_data          <= (status_rd | force_rd) ? rd_d : 8'h00;
            watchdog_restart <= status_wr;
            chip_reset       <= in_reset_d;
            if (state_q == rst_cause_pkg::ST_RELEASE) begin
                debug_halt_mode <= forced_q & ~mode_high;
            end
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    sequence s_force;
        state_q == rst_cause_pkg::ST_RUN && force_hit;
    endsequence

    property p_forced_clear;
        @(posedge clk) disable iff (sys_rst)
        s_force |=> (status_q == 8'h00);
    endproperty
    a_forced_clear: assert property (p_forced_clear) else $error("forced reset left flags");

    property p_wd_restart;
        @(posedge clk) disable iff (sys_rst)
        status_wr && state_q == rst_cause_pkg::ST_RUN && !any_src
            |=> watchdog_restart && $stable(status_q);
    endproperty
    a_wd_restart: assert property (p_wd_restart) else $error("status write misbehaved");

    property p_unused_zero;
        @(posedge clk) disable iff (sys_rst)
        status_rd |=> rd_data[2] == 1'b0 && rd_data[0] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused status bit set");

    property p_force_read;
        @(posedge clk) disable iff (sys_rst)
        force_rd && !status_rd |=> rd_data == 8'h00;
    endproperty
    a_force_read: assert property (p_force_read) else $error("force register read nonzero");

    property p_user_force;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && force_wr && !wr_from_debug && !other_src && !lv_src
            |=> state_q == rst_cause_pkg::ST_RUN;
    endproperty
    a_user_force: assert property (p_user_force) else $error("user write forced reset");

    property p_force_reset;
        @(posedge clk) disable iff (sys_rst)
        s_force |=> chip_reset;
    endproperty
    a_force_reset: assert property (p_force_reset) else $error("force did not reset");

    property p_lv_only;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && lv_src && !other_src && !force_hit
            |=> status_q == rst_cause_pkg::LOW_VOLTAGE_FLAGS;
    endproperty
    a_lv_only: assert property (p_lv_only) else $error("low-voltage flags wrong");

    property p_wd_blocked;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && !watchdog_enable && !force_hit
            |=> !status_q[rst_cause_pkg::WATCHDOG_BIT] || $stable(status_q);
    endproperty
    a_wd_blocked: assert property (p_wd_blocked) else $error("disabled watchdog reset");

    property p_stop_illegal;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && stop_insn && !stop_allow && !force_hit
            |=> status_q[rst_cause_pkg::BAD_OPCODE_BIT] ##1 chip_reset;
    endproperty
    a_stop_illegal: assert property (p_stop_illegal) else $error("stop not illegal");

    property p_power_on;
        @(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> status_q == rst_cause_pkg::POWER_ON_FLAGS;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power-on flags wrong");

    property p_status_read;
        @(posedge clk) disable iff (sys_rst)
        status_rd |=> rd_data == ($past(status_q) & rst_cause_pkg::STATUS_USED_MASK);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_no_power_on;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && any_src
            |=> !status_q[rst_cause_pkg::POWER_ON_BIT] && chip_reset;
    endproperty
    a_no_power_on: assert property (p_no_power_on) else $error("power-on flag kept");

    property p_pin_flag;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && pin_low && !force_hit
            |=> status_q[rst_cause_pkg::PIN_BIT] && chip_reset;
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag missing");

    property p_wd_flag;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && watchdog_timeout && watchdog_enable && !force_hit
            |=> status_q[rst_cause_pkg::WATCHDOG_BIT] && chip_reset;
    endproperty
    a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag missing");

    property p_bad_opcode;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && illegal_opcode && !force_hit
            |=> status_q[rst_cause_pkg::BAD_OPCODE_BIT] && chip_reset;
    endproperty
    a_bad_opcode: assert property (p_bad_opcode) else $error("opcode flag missing");

    property p_debug_illegal;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && enter_debug_insn && !debug_mode_allow && !force_hit
            |=> status_q[rst_cause_pkg::BAD_OPCODE_BIT] && chip_reset;
    endproperty
    a_debug_illegal: assert property (p_debug_illegal) else $error("debug insn legal");

    property p_bad_address;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RUN && illegal_address && !force_hit
            |=> status_q[rst_cause_pkg::BAD_ADDRESS_BIT] && chip_reset;
    endproperty
    a_bad_address: assert property (p_bad_address) else $error("address flag missing");

    property p_debug_entry;
        @(posedge clk) disable iff (sys_rst)
        state_q == rst_cause_pkg::ST_RELEASE
            |=> debug_halt_mode == $past(forced_q && !mode_high);
    endproperty
    a_debug_entry: assert property (p_debug_entry) else $error("debug entry wrong");

endmodule // reset_cause_and_debug_force_reset
`default_nettype wire

//--- sim/debug_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// serial debug host model
// ==========================================================
module debug_host_model (
    // clock
    input  wire logic       clk,
    // register write side
    output var  logic       force_wr,
    output var  logic       wr_from_debug,
    output var  logic [7:0] wr_data,
    // mode pin
    output var  logic       debug_mode_pin
);
    // idle: no write, mode pin pulled high
    initial begin
        force_wr       = 1'b0;
        wr_from_debug  = 1'b0;
        wr_data        = 8'h00;
        debug_mode_pin = 1'b1;
    end

    // one byte write held across one rising edge, data inverted on release
    task automatic write_byte(input logic dbg, input logic [7:0] data, input logic pin);
        @(negedge clk);
        force_wr       = 1'b1;
        wr_from_debug  = dbg;
        wr_data        = data;
        debug_mode_pin = pin;
        @(negedge clk);
        force_wr       = 1'b0;
        wr_from_debug  = 1'b0;
        wr_data        = ~data;
    endtask

    // mode pin back to its pulled-up idle level
    task automatic release_pin();
        debug_mode_pin = 1'b1;
    endtask
endmodule // debug_host_model
`default_nettype wire

//--- sim/reset_cause_and_debug_force_reset_bench.sv
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_debug_force_reset_bench;
    // ==========================================================
    // signals
    // ==========================================================
    logic       clk, sys_rst, ext_reset_n, debug_mode_pin;
    logic [9:0] src;
    logic       status_rd, status_wr, force_rd, force_wr, wr_from_debug;
    logic [7:0] wr_data, rd_data, last;
    logic       watchdog_restart, chip_reset, debug_halt_mode;
    int         err_total, checks;
    // source vectors {lv, lv_en, wd, wd_en, bad_opcode_flag, stop, stop_ok, dbg, dbg_ok, bad_address_flag}
    localparam logic [9:0] CORNER [11] = '{10'h300, 10'h200, 10'h010, 10'h018, 10'h004,
        10'h006, 10'h0c0, 10'h080, 10'h020, 10'h001, 10'h3ff};

    // clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // design and host model
    reset_cause_and_debug_force_reset #(.HOLD_CYCLES(2)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .ext_reset_n(ext_reset_n),
        .debug_mode_pin(debug_mode_pin), .low_voltage_trip(src[9]),
        .low_voltage_reset_enable(src[8]), .watchdog_timeout(src[7]),
        .watchdog_enable(src[6]), .illegal_opcode(src[5]), .stop_insn(src[4]),
        .stop_allow(src[3]), .enter_debug_insn(src[2]), .debug_mode_allow(src[1]),
        .illegal_address(src[0]), .status_rd(status_rd), .status_wr(status_wr),
        .force_rd(force_rd), .force_wr(force_wr), .wr_from_debug(wr_from_debug),
        .wr_data(wr_data), .rd_data(rd_data), .watchdog_restart(watchdog_restart),
        .chip_reset(chip_reset), .debug_halt_mode(debug_halt_mode)
    );
    debug_host_model i_host (
        .clk(clk), .force_wr(force_wr), .wr_from_debug(wr_from_debug),
        .wr_data(wr_data), .debug_mode_pin(debug_mode_pin)
    );

    // ==========================================================
    // helpers
    // ==========================================================
    // expected status word for a source vector
    function automatic logic [7:0] cause(input logic [9:0] s);
        cause = 8'h00;
        cause[rst_cause_pkg::LOW_VOLTAGE_BIT] = s[9] & s[8];
        cause[rst_cause_pkg::WATCHDOG_BIT]    = s[7] & s[6];
        cause[rst_cause_pkg::BAD_OPCODE_BIT]  = s[5] | (s[4] & ~s[3]) | (s[2] & ~s[1]);
        cause[rst_cause_pkg::BAD_ADDRESS_BIT] = s[0];
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        checks++;
        if (seen !== expd) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic print_verdict();
        $display("counts: %0d checks, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bounded wait until the chip runs again
    task automatic wait_run();
        int n;
        n = 0;
        while (chip_reset !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            err_total++;
            print_verdict();
        end
    endtask

    // sel high reads status, low reads the force register
    task automatic read_reg(input logic sel, input logic [7:0] expd);
        @(negedge clk);
        status_rd = sel;
        force_rd  = ~sel;
        @(negedge clk);
        status_rd = 1'b0;
        force_rd  = 1'b0;
        check(rd_data, expd);
    endtask

    // one-cycle source pulse, then reset entry and flags
    task automatic fire(input logic [9:0] s);
        logic [7:0] e;
        e = cause(s);
        @(negedge clk);
        src = s;
        @(negedge clk);
        src = 10'h000;
        check({7'h00, chip_reset}, {7'h00, e != 8'h00});
        wait_run();
        if (e != 8'h00) last = e;
        read_reg(1'b1, last);
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        void'($urandom(53));
        {sys_rst, ext_reset_n, src, status_rd, status_wr, force_rd} = {2'b11, 13'h0};
        {err_total, checks} = 0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        wait_run();
        last = 8'h82;
        read_reg(1'b1, last);
        $display("test power-on done");
        foreach (CORNER[i]) fire(CORNER[i]);
        repeat (40) fire(10'($urandom()));
        $display("test sources done");
        @(negedge clk);
        ext_reset_n = 1'b0;
        repeat (6) @(negedge clk);
        check({7'h00, chip_reset}, 8'h01);
        ext_reset_n = 1'b1;
        wait_run();
        last = 8'h40;
        read_reg(1'b1, last);
        $display("test pin done");
        @(negedge clk);
        status_wr = 1'b1;
        @(negedge clk);
        status_wr = 1'b0;
        check({7'h00, watchdog_restart}, 8'h01);
        read_reg(1'b1, last);
        read_reg(1'b0, rst_cause_pkg::FORCE_READ_VAL);
        i_host.write_byte(1'b0, 8'h01, 1'b1);
        check({7'h00, chip_reset}, 8'h00);
        i_host.write_byte(1'b1, 8'hfe, 1'b1);
        check({7'h00, chip_reset}, 8'h00);
        for (int p = 1; p >= 0; p--) begin
            i_host.write_byte(1'b1, 8'h01, p[0]);
            check({7'h00, chip_reset}, 8'h01);
            repeat (8) @(negedge clk);
            i_host.release_pin();
            wait_run();
            check({7'h00, debug_halt_mode}, {7'h00, ~p[0]});
            last = rst_cause_pkg::STATUS_CLEAR;
            read_reg(1'b1, last);
        end
        $display("test force done");
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        wait_run();
        read_reg(1'b1, 8'h82);
        check({7'h00, debug_halt_mode}, 8'h00);
        $display("test second power-on done");
        print_verdict();
    end
endmodule // reset_cause_and_debug_force_reset_bench
`default_nettype wire
